/* File: verilog/itc_interval_timer.sv */
// Crystal-timed real-time clock and interval counter with special-function register port
// What this block does
// - Counts on crystal ticks, not core activity; keeps running in power-down.
// - Timeout spans one 128th second up to 256 hours (compare value zero).
// - Interval counter advances each time the selected timebase register increments.
// - Counter equal to compare value sets flag bit 2 and requests interrupt.
// - Flag set in power-down with interrupt enabled wakes the device to its vector.
// - Bit 6 set makes hours count 0 to 23, else 0 to 255.
// - Bits 5:4 pick timebase: 128th second, seconds, minutes, hours.
// - Single-interval bit 3 makes a timeout clear the interval enable.
// - Without single-interval, counter reloads at each timeout and keeps counting.
// - Flag stays set until software clears it.
// - Bit 1 enables the interval counter.
// - Bit 0 routes the crystal clock to all counters.
// - Clearing bit 0 stops counters and restores last written time values.
// - Time registers accept writes while bit 0 is low.
// - Bit 7 of control is unimplemented; writes ignored.
// - Compare register holds 8 bits, resets to zero.
// - Control register resets to zero; written as a whole byte only.
// - Fraction counts 0 to 127 every 128th second, carries to seconds.
// - Seconds count 0 to 59, carry to minutes.
// - Minutes count 0 to 59, carry to hours.
`timescale 1ns/1ps
module itc_interval_timer (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_xtal_tick,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic       i_sfr_wr,
	input  wire logic       i_sfr_rd,
	input  wire logic [7:0] i_sfr_wdata,
	input  wire logic       i_irq_enable,
	input  wire logic       i_power_down,
	output logic      [7:0] o_sfr_rdata,
	output logic            o_busy,
	output logic            o_irq,
	output logic            o_wake
);
	import itc_pkg::*;

	logic       pend_reg;
	logic       pend_wr_reg;
	logic [7:0] pend_addr_reg;
	logic [7:0] pend_data_reg;
	logic [7:0] pre_reg;
	logic [6:0] frac_reg;
	logic [5:0] one_hz_tally_reg;
	logic [5:0] minute_reg;
	logic [7:0] hour_reg;
	logic [6:0] frac_shadow_reg;
	logic [5:0] one_hz_shadow_reg;
	logic [5:0] minute_shadow_reg;
	logic [7:0] hour_shadow_reg;
	logic [7:0] interval_count_reg;
	logic [7:0] interval_compare_reg;
	logic [6:0] tic_control_reg;
	logic [6:0] tic_control_next;
	logic       pend_next;
	logic       pend_wr_next;
	logic [7:0] pend_addr_next;
	logic [7:0] pend_data_next;
	logic [7:0] pre_next;
	logic [6:0] frac_next;
	logic [5:0] one_hz_tally_next;
	logic [5:0] minute_next;
	logic [7:0] hour_next;
	logic [6:0] frac_shadow_next;
	logic [5:0] one_hz_shadow_next;
	logic [5:0] minute_shadow_next;
	logic [7:0] hour_shadow_next;
	logic [7:0] interval_count_next;
	logic [7:0] interval_compare_next;
	logic [7:0] sfr_rdata_next;
	logic       busy_next;
	logic       irq_next;
	logic       wake_next;

	// Accesses complete only on a crystal tick, so software sees the slow pace on o_busy
	wire        commit        = pend_reg & i_xtal_tick;
	wire        do_write      = commit & pend_wr_reg;
	wire        do_read       = commit & ~pend_wr_reg;
	wire        wr_control    = do_write & (pend_addr_reg == ADDR_CONTROL);
	wire        wr_compare    = do_write & (pend_addr_reg == ADDR_COMPARE);
	wire        time_wr_ok    = do_write & ~tic_control_reg[BIT_CLK_EN];
	wire        wr_fraction   = time_wr_ok & (pend_addr_reg == ADDR_FRACTION);
	wire        wr_one_hz     = time_wr_ok & (pend_addr_reg == ADDR_ONE_HZ);
	wire        wr_minute     = time_wr_ok & (pend_addr_reg == ADDR_MINUTE);
	wire        wr_hour       = time_wr_ok & (pend_addr_reg == ADDR_HOUR);
	wire        capture       = ~pend_reg & (i_sfr_wr | i_sfr_rd);

	wire        clk_en        = tic_control_reg[BIT_CLK_EN];
	wire        int_en        = tic_control_reg[BIT_INT_EN];
	wire        flag          = tic_control_reg[BIT_FLAG];
	wire        single        = tic_control_reg[BIT_SINGLE];
	wire [1:0]  timebase_sel  = tic_control_reg[BIT_TB_HI:BIT_TB_LO];
	wire        hour24        = tic_control_reg[BIT_HOUR24];

	wire        advance       = i_xtal_tick & clk_en;
	wire        pre_wrap      = advance & (pre_reg == PRE_MAX);
	wire        frac_wrap     = pre_wrap & (frac_reg == FRAC_MAX);
	wire        one_hz_wrap   = frac_wrap & (one_hz_tally_reg == SEC_MAX);
	wire        minute_wrap   = one_hz_wrap & (minute_reg == MIN_MAX);
	wire [7:0]  hour_max      = hour24 ? HOUR_MAX_24 : HOUR_MAX_FULL;
	wire        hour_wrap     = minute_wrap & (hour_reg == hour_max);

	wire [3:0]  tb_events     = {minute_wrap, one_hz_wrap, frac_wrap, pre_wrap};
	wire        tb_event      = tb_events[timebase_sel];
	wire        interval_step = int_en & tb_event;
	wire [7:0]  interval_inc  = interval_count_reg + 8'h01;
	wire        match         = interval_step & (interval_inc == interval_compare_reg);

	wire [7:0]  read_mux =
		(pend_addr_reg == ADDR_CONTROL)  ? {1'b0, tic_control_reg} :
		(pend_addr_reg == ADDR_FRACTION) ? {1'b0, frac_reg} :
		(pend_addr_reg == ADDR_ONE_HZ)   ? {2'b00, one_hz_tally_reg} :
		(pend_addr_reg == ADDR_MINUTE)   ? {2'b00, minute_reg} :
		(pend_addr_reg == ADDR_HOUR)     ? hour_reg :
		(pend_addr_reg == ADDR_COMPARE)  ? interval_compare_reg : UNMAPPED_READ;

	// Bit 7 is never stored; a hardware set of the flag wins over a same-tick clear
	always_comb begin
		tic_control_next = tic_control_reg;
		if (wr_control) begin
			tic_control_next = pend_data_reg[6:0];
		end
		if (match & single) begin
			tic_control_next[BIT_INT_EN] = 1'b0;
		end
		if (match) begin
			tic_control_next[BIT_FLAG] = 1'b1;
		end
	end

	// A new request is only taken once the previous one has committed
	assign pend_next      = capture | (pend_reg & ~commit);
	assign pend_wr_next   = capture ? i_sfr_wr : pend_wr_reg;
	assign pend_addr_next = capture ? i_sfr_addr : pend_addr_reg;
	assign pend_data_next = capture ? i_sfr_wdata : pend_data_reg;

	// Shadows keep the last time software wrote, for reload when the clock stops
	assign frac_shadow_next   = wr_fraction ? pend_data_reg[6:0] : frac_shadow_reg;
	assign one_hz_shadow_next = wr_one_hz ? pend_data_reg[5:0] : one_hz_shadow_reg;
	assign minute_shadow_next = wr_minute ? pend_data_reg[5:0] : minute_shadow_reg;
	assign hour_shadow_next   = wr_hour ? pend_data_reg : hour_shadow_reg;

	// With the clock disabled the time registers track the last written values
	assign pre_next =
		~clk_en  ? 8'h00 :
		pre_wrap ? 8'h00 :
		advance  ? pre_reg + 8'h01 : pre_reg;

	assign frac_next =
		~clk_en   ? frac_shadow_reg :
		frac_wrap ? 7'h00 :
		pre_wrap  ? frac_reg + 7'h01 : frac_reg;

	assign one_hz_tally_next =
		~clk_en     ? one_hz_shadow_reg :
		one_hz_wrap ? 6'h00 :
		frac_wrap   ? one_hz_tally_reg + 6'h01 : one_hz_tally_reg;

	assign minute_next =
		~clk_en     ? minute_shadow_reg :
		minute_wrap ? 6'h00 :
		one_hz_wrap ? minute_reg + 6'h01 : minute_reg;

	assign hour_next =
		~clk_en     ? hour_shadow_reg :
		hour_wrap   ? 8'h00 :
		minute_wrap ? hour_reg + 8'h01 : hour_reg;

	// Held at zero while disabled so every enable starts a full interval
	assign interval_count_next =
		(~int_en | match) ? 8'h00 :
		interval_step     ? interval_inc : interval_count_reg;
	assign interval_compare_next = wr_compare ? pend_data_reg : interval_compare_reg;

	assign sfr_rdata_next = do_read ? read_mux : o_sfr_rdata;
	assign busy_next      = pend_next;
	assign irq_next       = flag & i_irq_enable;
	assign wake_next      = flag & i_irq_enable & i_power_down;

	// One flop per register; the next values above carry every decision
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_wr_reg <= 1'b0;
		end else begin
			pend_wr_reg <= pend_wr_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_addr_reg <= 8'h00;
		end else begin
			pend_addr_reg <= pend_addr_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_data_reg <= 8'h00;
		end else begin
			pend_data_reg <= pend_data_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tic_control_reg <= CONTROL_RESET[6:0];
		end else begin
			tic_control_reg <= tic_control_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			interval_compare_reg <= COMPARE_RESET;
		end else begin
			interval_compare_reg <= interval_compare_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			frac_shadow_reg <= TIME_RESET[6:0];
		end else begin
			frac_shadow_reg <= frac_shadow_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			one_hz_shadow_reg <= TIME_RESET[5:0];
		end else begin
			one_hz_shadow_reg <= one_hz_shadow_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			minute_shadow_reg <= TIME_RESET[5:0];
		end else begin
			minute_shadow_reg <= minute_shadow_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hour_shadow_reg <= TIME_RESET;
		end else begin
			hour_shadow_reg <= hour_shadow_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pre_reg <= 8'h00;
		end else begin
			pre_reg <= pre_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			frac_reg <= TIME_RESET[6:0];
		end else begin
			frac_reg <= frac_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			one_hz_tally_reg <= TIME_RESET[5:0];
		end else begin
			one_hz_tally_reg <= one_hz_tally_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			minute_reg <= TIME_RESET[5:0];
		end else begin
			minute_reg <= minute_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hour_reg <= TIME_RESET;
		end else begin
			hour_reg <= hour_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			interval_count_reg <= 8'h00;
		end else begin
			interval_count_reg <= interval_count_next;
		end
	end

	// Outputs come straight from flops so the core always samples settled levels
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sfr_rdata <= 8'h00;
		end else begin
			o_sfr_rdata <= sfr_rdata_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= busy_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= irq_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= wake_next;
		end
	end

endmodule : itc_interval_timer

/* File: verilog/itc_pkg.sv */
// Constants for the crystal-timed interval counter
package itc_pkg;
	localparam int          XTAL_HZ         = 32768;
	localparam int          FRAC_PER_SEC    = 128;
	localparam int          PRE_TICKS       = XTAL_HZ / FRAC_PER_SEC;
	localparam logic [7:0]  PRE_MAX         = 8'(PRE_TICKS - 1);
	localparam logic [6:0]  FRAC_MAX        = 7'h7f;
	localparam logic [5:0]  SEC_MAX         = 6'h3b;
	localparam logic [5:0]  MIN_MAX         = 6'h3b;
	localparam logic [7:0]  HOUR_MAX_24     = 8'h17;
	localparam logic [7:0]  HOUR_MAX_FULL   = 8'hff;

	localparam logic [7:0]  ADDR_CONTROL    = 8'ha1;
	localparam logic [7:0]  ADDR_FRACTION   = 8'ha2;
	localparam logic [7:0]  ADDR_ONE_HZ     = 8'ha3;
	localparam logic [7:0]  ADDR_MINUTE     = 8'ha4;
	localparam logic [7:0]  ADDR_HOUR       = 8'ha5;
	localparam logic [7:0]  ADDR_COMPARE    = 8'ha6;

	localparam int          BIT_CLK_EN      = 0;
	localparam int          BIT_INT_EN      = 1;
	localparam int          BIT_FLAG        = 2;
	localparam int          BIT_SINGLE      = 3;
	localparam int          BIT_TB_LO       = 4;
	localparam int          BIT_TB_HI       = 5;
	localparam int          BIT_HOUR24      = 6;

	localparam logic [7:0]  CONTROL_RESET   = 8'h00;
	localparam logic [7:0]  COMPARE_RESET   = 8'h00;
	localparam logic [7:0]  TIME_RESET      = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
endpackage : itc_pkg

/* File: tb/itc_interval_timer_monitor.sv */
// Port-level assertions for the interval timer
`timescale 1ns/1ps
module itc_interval_timer_monitor (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_xtal_tick,
	input wire logic [7:0] i_sfr_addr,
	input wire logic       i_sfr_wr,
	input wire logic       i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic       i_irq_enable,
	input wire logic       i_power_down,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic       o_busy,
	input wire logic       o_irq,
	input wire logic       o_wake
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_wake_needs_irq: assert property (o_wake |-> o_irq)
		else $error("wake without interrupt");
	a_wake_in_sleep: assert property (o_wake |-> $past(i_power_down))
		else $error("wake outside power-down");
	a_irq_when_enabled: assert property (o_irq |-> $past(i_irq_enable))
		else $error("interrupt while disabled");
	a_busy_from_request: assert property ($rose(o_busy) |-> $past(i_sfr_wr || i_sfr_rd) || $past(i_sfr_wr || i_sfr_rd, 2))
		else $error("busy without request");
	a_commit_on_tick: assert property (o_busy && i_xtal_tick |=> !o_busy)
		else $error("access not done after tick");
	a_done_after_tick: assert property ($fell(o_busy) |-> $past(i_xtal_tick))
		else $error("access done without tick");
	a_rdata_held: assert property ($changed(o_sfr_rdata) |-> $fell(o_busy))
		else $error("read data moved outside commit");
	a_irq_moves_on_tick: assert property ($changed(o_irq) |-> $past(i_xtal_tick, 2) || ($past(i_irq_enable) != $past(i_irq_enable, 2)))
		else $error("interrupt changed without cause");
	c_access_done: cover property ($fell(o_busy));
	c_irq_raised: cover property ($rose(o_irq));
	c_wake_raised: cover property ($rose(o_wake));
endmodule : itc_interval_timer_monitor

bind itc_interval_timer itc_interval_timer_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_xtal_tick(i_xtal_tick),
	.i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
	.i_irq_enable(i_irq_enable), .i_power_down(i_power_down), .o_sfr_rdata(o_sfr_rdata), .o_busy(o_busy),
	.o_irq(o_irq), .o_wake(o_wake));

/* File: tb/testbench.sv */
// Self-checking bench for the interval timer
`timescale 1ns/1ps
module testbench;
	import itc_pkg::*;
	logic       clk = 1'b0, rst = 1'b1, tick = 1'b0, wr = 1'b0, rd = 1'b0, irq_en = 1'b0, pd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rnd;
	logic       busy, irq, wake, busy_q = 1'b0;
	logic [8:0] notes[$];
	int         n_errors = 0, n_compared = 0, cycles = 0, seed = 97;
	always #2 clk = ~clk;
	itc_interval_timer u_dut (.i_clk(clk), .i_rst(rst), .i_xtal_tick(tick), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_rd(rd), .i_sfr_wdata(wdata), .i_irq_enable(irq_en), .i_power_down(pd), .o_sfr_rdata(rdata),
		.o_busy(busy), .o_irq(irq), .o_wake(wake));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	// Bit 8 of a note marks a read whose data must be compared
	task automatic acc(input logic is_rd, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		notes.push_back({is_rd, exp});
		@(negedge clk);
		addr = a;
		wdata = d;
		rd = is_rd;
		wr = ~is_rd;
		@(negedge clk);
		rd = 1'b0;
		wr = 1'b0;
		@(negedge clk);
		while (busy) @(negedge clk);
		@(negedge clk);
	endtask : acc
	task automatic wait_irq();
		for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(negedge clk);
		check({7'h00, irq}, 8'h01);
	endtask : wait_irq
	// Crystal ticks arrive at random, so commits land at varying distances
	always @(negedge clk) begin
		tick <= 1'($random(seed));
		cycles++;
		if (cycles > 60000) begin
			n_errors++;
			results();
		end
	end
	always @(negedge clk) begin
		busy_q <= busy;
		if (busy_q && !busy && notes.size() > 0) begin
			if (notes[0][8]) check(rdata, notes[0][7:0]);
			void'(notes.pop_front());
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		acc(1'b1, ADDR_CONTROL, 8'h00, CONTROL_RESET);
		acc(1'b1, ADDR_COMPARE, 8'h00, COMPARE_RESET);
		acc(1'b1, 8'ha7, 8'h00, UNMAPPED_READ);
		rnd = 8'($random(seed));
		acc(1'b0, ADDR_COMPARE, rnd, 8'h00);
		acc(1'b1, ADDR_COMPARE, 8'h00, rnd);
		acc(1'b0, ADDR_CONTROL, 8'hc0, 8'h00);
		acc(1'b1, ADDR_CONTROL, 8'h00, 8'h40);
		acc(1'b0, ADDR_FRACTION, 8'h7e, 8'h00);
		acc(1'b1, ADDR_FRACTION, 8'h00, 8'h7e);
		acc(1'b0, ADDR_COMPARE, 8'h02, 8'h00);
		irq_en = 1'b1;
		pd = 1'b1;
		acc(1'b0, ADDR_CONTROL, 8'h0b, 8'h00);
		wait_irq();
		check({7'h00, wake}, 8'h01);
		acc(1'b1, ADDR_CONTROL, 8'h00, 8'h0d);
		acc(1'b1, ADDR_ONE_HZ, 8'h00, 8'h01);
		acc(1'b0, ADDR_FRACTION, 8'h11, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h00, 8'h00);
		check({7'h00, irq}, 8'h00);
		acc(1'b1, ADDR_FRACTION, 8'h00, 8'h7e);
		pd = 1'b0;
		acc(1'b0, ADDR_COMPARE, 8'h01, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h03, 8'h00);
		wait_irq();
		acc(1'b0, ADDR_CONTROL, 8'h03, 8'h00);
		check({7'h00, irq}, 8'h00);
		wait_irq();
		acc(1'b1, ADDR_CONTROL, 8'h00, 8'h07);
		// Slower timebases, preloaded one step short of their carry
		acc(1'b0, ADDR_CONTROL, 8'h00, 8'h00);
		acc(1'b0, ADDR_FRACTION, 8'h7f, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h13, 8'h00);
		wait_irq();
		check({7'h00, wake}, 8'h00);
		acc(1'b1, ADDR_ONE_HZ, 8'h00, 8'h01);
		acc(1'b0, ADDR_CONTROL, 8'h00, 8'h00);
		acc(1'b0, ADDR_ONE_HZ, 8'h3b, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h23, 8'h00);
		wait_irq();
		acc(1'b1, ADDR_MINUTE, 8'h00, 8'h01);
		acc(1'b1, ADDR_ONE_HZ, 8'h00, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h00, 8'h00);
		acc(1'b0, ADDR_MINUTE, 8'h3b, 8'h00);
		acc(1'b0, ADDR_HOUR, 8'h17, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h73, 8'h00);
		wait_irq();
		acc(1'b1, ADDR_HOUR, 8'h00, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h00, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h33, 8'h00);
		wait_irq();
		acc(1'b1, ADDR_HOUR, 8'h00, 8'h18);
		acc(1'b0, ADDR_CONTROL, 8'h00, 8'h00);
		acc(1'b0, ADDR_CONTROL, 8'h01, 8'h00);
		repeat (1200) @(negedge clk);
		check({7'h00, irq}, 8'h00);
		acc(1'b1, ADDR_CONTROL, 8'h00, 8'h01);
		results();
	end
endmodule : testbench
